// ---- verilog/oms_top.sv ----
/*
 * Operation mode selector: picks the start command and running frequency source
 * from the stored operation mode setting and the active mode, under an AXI4-Lite slave.
 * Assumes terminal and panel pins are asynchronous, the network link and the
 * drive_running flag come from logic on aclk, and one bus master.
 */
// Behaviour
// RQ1: Setting 0 starts in external mode and allows panel/external switching.
// RQ2: Setting 1 fixes panel mode and refuses every mode change.
// RQ3: Setting 2 stays external, never panel; external/network switching allowed.
// RQ4: Setting 3 starts only from terminals; frequency from panel or external inputs.
// RQ5: Setting 3 uses terminals 4-5 only with current select on; multi-speed valid.
// RQ6: Setting 4 takes frequency from external inputs, start only from panel keys.
// RQ7: Setting 6 switches among panel, external, network keeping the running state.
// RQ8: Setting 7 is external; panel allowed only while interlock input is on.
// RQ9: Setting 7 with interlock off rejects every switch into panel mode.
// RQ10: Setting writes are accepted only while the drive is stopped.
// RQ11: Outside party drives the interlock input to govern panel entry.
// RQ12: Setting writes outside 0,1,2,3,4,6,7 are rejected, old value kept.
`timescale 1ns/100ps
`include "oms_cfg.svh"

module oms_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`OMS_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`OMS_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire oms_pkg::oms_pins_t pins_in,
	input wire oms_pkg::oms_net_t net_in,
	input wire logic drive_running,
	output oms_pkg::oms_drive_t drive_cmd,
	output oms_pkg::oms_ind_t mode_ind
);

	import oms_pkg::*;

	// ==========================================================================
	// State.
	localparam oms_state_t ST_RESET = '{
		setting: `OMS_SET_RESET,
		mode: OMS_EXT,
		sw_target: `OMS_TGT_RESET,
		default: '0
	};

	oms_state_t st_reg;
	oms_state_t st_next;
	oms_pins_t pins;

	// ==========================================================================
	// Pin synchronisers.
	oms_sync #(
		.W($bits(oms_pins_t))
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(pins_in),
		.q(pins)
	);

	// ==========================================================================
	// Decoding functions.

	// Value 5 is a gap in the setting range and is refused like any other stray value.
	function automatic logic setting_valid(input logic [31:0] v);
		setting_valid = (v[31:`OMS_SET_W] == '0) && (v[`OMS_SET_W-1:0] != `OMS_SET_UNUSED);
	endfunction

	function automatic oms_opmode_t home_mode(input logic [`OMS_SET_W-1:0] s);
		case (s)
			`OMS_SET_PANEL_FIXED: home_mode = OMS_PANEL; // [RQ2]
			`OMS_SET_COMBINED_1: home_mode = OMS_COMB; // [RQ4]
			`OMS_SET_COMBINED_2: home_mode = OMS_COMB; // [RQ6]
			default: home_mode = OMS_EXT; // [RQ1] [RQ3] [RQ8]
		endcase
	endfunction

	function automatic logic switch_allowed(
		input logic [`OMS_SET_W-1:0] s,
		input logic [`OMS_TGT_W-1:0] tgt,
		input logic interlock
	);
		case (s)
			`OMS_SET_EXT_PANEL: switch_allowed = (tgt == `OMS_TGT_EXT) || (tgt == `OMS_TGT_PANEL); // [RQ1]
			`OMS_SET_EXT_FIXED: switch_allowed = (tgt == `OMS_TGT_EXT) || (tgt == `OMS_TGT_NET); // [RQ3]
			`OMS_SET_SWITCHOVER: switch_allowed = (tgt != `OMS_TGT_NONE); // [RQ7]
			`OMS_SET_INTERLOCK: begin
				switch_allowed = (tgt == `OMS_TGT_EXT) || ((tgt == `OMS_TGT_PANEL) && interlock); // [RQ8] [RQ9] [RQ11]
			end
			default: switch_allowed = 1'b0; // [RQ2]
		endcase
	endfunction

	function automatic oms_opmode_t target_mode(input logic [`OMS_TGT_W-1:0] tgt);
		case (tgt)
			`OMS_TGT_PANEL: target_mode = OMS_PANEL;
			`OMS_TGT_NET: target_mode = OMS_NET;
			default: target_mode = OMS_EXT;
		endcase
	endfunction

	// Priority of external frequency sources: multi-speed, jog, then analog.
	function automatic logic [`OMS_FREQ_W-1:0] ext_freq(input oms_pins_t p);
		if (p.multi_speed_valid) begin
			ext_freq = p.multi_speed_freq;
		end else if (p.jog_active) begin
			ext_freq = p.jog_freq;
		end else if (p.current_input_select) begin
			ext_freq = p.analog4_freq;
		end else begin
			ext_freq = p.analog2_freq;
		end
	endfunction

	function automatic logic addr_mapped(input logic [`OMS_AW-1:0] a);
		addr_mapped = (a == `OMS_OFS_SETTING) || (a == `OMS_OFS_SWITCH) || (a == `OMS_OFS_STATUS);
	endfunction

	// ==========================================================================
	// Source selection.
	logic src_fwd;
	logic src_rev;
	logic [`OMS_FREQ_W-1:0] src_freq;

	always_comb begin
		src_fwd = pins.forward_start_input;
		src_rev = pins.reverse_start_input;
		src_freq = ext_freq(pins);
		case (st_reg.mode)
			OMS_EXT: begin
				src_fwd = pins.forward_start_input;
				src_rev = pins.reverse_start_input;
				src_freq = ext_freq(pins);
			end
			OMS_PANEL: begin
				src_fwd = pins.panel_forward_key;
				src_rev = pins.panel_reverse_key;
				src_freq = pins.panel_freq;
			end
			OMS_NET: begin
				src_fwd = net_in.start_fwd;
				src_rev = net_in.start_rev;
				src_freq = net_in.freq;
			end
			OMS_COMB: begin
				if (st_reg.setting == `OMS_SET_COMBINED_2) begin
					src_fwd = pins.panel_forward_key; // [RQ6]
					src_rev = pins.panel_reverse_key; // [RQ6]
					src_freq = ext_freq(pins); // [RQ6]
				end else begin
					src_fwd = pins.forward_start_input; // [RQ4]
					src_rev = pins.reverse_start_input; // [RQ4]
					if (pins.multi_speed_valid) begin
						src_freq = pins.multi_speed_freq; // [RQ5]
					end else if (pins.current_input_select) begin
						src_freq = pins.analog4_freq; // [RQ5]
					end else begin
						src_freq = pins.panel_freq; // [RQ4]
					end
				end
			end
			default: begin
				src_fwd = 1'b0;
				src_rev = 1'b0;
			end
		endcase
	end

	// ==========================================================================
	// Bus handshakes.
	logic aw_hs;
	logic w_hs;
	logic ar_hs;

	assign s_axi_awready = !st_reg.aw_have && !st_reg.bvalid;
	assign s_axi_wready = !st_reg.w_have && !st_reg.bvalid;
	assign s_axi_arready = !st_reg.rvalid;
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign ar_hs = s_axi_arvalid && s_axi_arready;

	// ==========================================================================
	// Read data.
	logic [31:0] status_word;

	always_comb begin
		status_word = '0;
		status_word[`OMS_ST_MODE_HI:`OMS_ST_MODE_LO] = st_reg.mode;
		status_word[`OMS_ST_RUNNING] = drive_running;
		status_word[`OMS_ST_HOLD] = st_reg.hold;
		status_word[`OMS_ST_REJ_SET] = st_reg.rej_set;
		status_word[`OMS_ST_REJ_SW] = st_reg.rej_sw;
		status_word[`OMS_ST_INTERLOCK] = pins.panel_interlock_input;
	end

	// ==========================================================================
	// Next state.
	always_comb begin
		logic [`OMS_TGT_W-1:0] tgt;
		logic stopped_or_free;
		logic hold_set;
		tgt = '0;
		stopped_or_free = 1'b0;
		hold_set = 1'b0;
		st_next = st_reg;

		// Write address and data may arrive in either order.
		if (aw_hs) begin
			st_next.aw_have = 1'b1;
			st_next.awaddr = s_axi_awaddr;
		end
		if (w_hs) begin
			st_next.w_have = 1'b1;
			st_next.wdata = s_axi_wdata;
			st_next.wstrb0 = s_axi_wstrb[0];
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end

		// All fields live in byte 0, so a write without that lane changes nothing.
		if (st_reg.aw_have && st_reg.w_have) begin
			st_next.aw_have = 1'b0;
			st_next.w_have = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = `OMS_RESP_OKAY;
			case (st_reg.awaddr)
				`OMS_OFS_SETTING: begin
					if (st_reg.wstrb0) begin
						if (drive_running || !setting_valid(st_reg.wdata)) begin
							st_next.rej_set = 1'b1; // [RQ10] [RQ12]
							st_next.bresp = `OMS_RESP_SLVERR;
						end else begin
							st_next.setting = st_reg.wdata[`OMS_SET_W-1:0];
							st_next.mode = home_mode(st_reg.wdata[`OMS_SET_W-1:0]); // [RQ1]
							st_next.hold = 1'b0;
						end
					end
				end
				`OMS_OFS_SWITCH: begin
					if (st_reg.wstrb0) begin
						tgt = st_reg.wdata[`OMS_TGT_W-1:0];
						st_next.sw_target = tgt;
						// Only the switch-over setting may change modes under a running drive.
						stopped_or_free = !drive_running || (st_reg.setting == `OMS_SET_SWITCHOVER);
						if (switch_allowed(st_reg.setting, tgt, pins.panel_interlock_input) && stopped_or_free) begin
							st_next.mode = target_mode(tgt); // [RQ7] [RQ8]
							st_next.hold = drive_running; // [RQ7]
							hold_set = drive_running;
						end else begin
							st_next.rej_sw = 1'b1; // [RQ2] [RQ3] [RQ9]
							st_next.bresp = `OMS_RESP_SLVERR;
						end
					end
				end
				`OMS_OFS_STATUS: begin
					if (st_reg.wstrb0) begin
						if (st_reg.wdata[`OMS_ST_REJ_SET]) begin
							st_next.rej_set = 1'b0;
						end
						if (st_reg.wdata[`OMS_ST_REJ_SW]) begin
							st_next.rej_sw = 1'b0;
						end
					end
				end
				default: begin
					st_next.bresp = `OMS_RESP_SLVERR;
				end
			endcase
		end

		// Read channel answers one cycle after the address is taken.
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (ar_hs) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = addr_mapped(s_axi_araddr) ? `OMS_RESP_OKAY : `OMS_RESP_SLVERR;
			case (s_axi_araddr)
				`OMS_OFS_SETTING: st_next.rdata = {{(32-`OMS_SET_W){1'b0}}, st_reg.setting};
				`OMS_OFS_SWITCH: st_next.rdata = {{(32-`OMS_TGT_W){1'b0}}, st_reg.sw_target};
				`OMS_OFS_STATUS: st_next.rdata = status_word;
				default: st_next.rdata = '0;
			endcase
		end

		// Drive command. During a hold the old command runs on while the drive runs, until the
		// new source issues its own start, so a switch never bumps the motor.
		if (st_reg.hold && drive_running && !(src_fwd || src_rev)) begin
			st_next.drive = st_reg.drive; // [RQ7]
		end else begin
			// An old hold ends here, but a hold set by a switch in this same cycle survives.
			st_next.hold = hold_set; // [RQ7]
			// Both starts on at once is treated as a stop.
			st_next.drive.run_fwd = src_fwd && !src_rev;
			st_next.drive.run_rev = src_rev && !src_fwd;
			st_next.drive.freq = src_freq;
		end
	end

	// ==========================================================================
	// Registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= ST_RESET; // [RQ1]
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================================
	// Outputs.
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rresp = st_reg.rresp;
	assign s_axi_rdata = st_reg.rdata;
	assign drive_cmd = st_reg.drive;
	assign mode_ind.external_mode_indicator = (st_reg.mode == OMS_EXT) || (st_reg.mode == OMS_COMB);
	assign mode_ind.panel_mode_indicator = (st_reg.mode == OMS_PANEL) || (st_reg.mode == OMS_COMB);
	assign mode_ind.net_mode_indicator = (st_reg.mode == OMS_NET);

endmodule

// ---- verilog/oms_cfg.svh ----
/*
 * Offsets, field positions, codes and reset values of the operation mode selector.
 * Assumes it is included by the package and by the design files by bare name.
 */
`ifndef OMS_CFG_SVH
`define OMS_CFG_SVH

// ==========================================================================
// Register map, byte addresses on an 8-bit AXI4-Lite address.
`define OMS_AW 8
`define OMS_OFS_SETTING 8'h00
`define OMS_OFS_SWITCH 8'h04
`define OMS_OFS_STATUS 8'h08

// ==========================================================================
// Operation mode setting values.
`define OMS_SET_W 3
`define OMS_SET_EXT_PANEL 3'h0
`define OMS_SET_PANEL_FIXED 3'h1
`define OMS_SET_EXT_FIXED 3'h2
`define OMS_SET_COMBINED_1 3'h3
`define OMS_SET_COMBINED_2 3'h4
`define OMS_SET_UNUSED 3'h5
`define OMS_SET_SWITCHOVER 3'h6
`define OMS_SET_INTERLOCK 3'h7
`define OMS_SET_RESET 3'h0

// ==========================================================================
// Switch request targets.
`define OMS_TGT_W 2
`define OMS_TGT_EXT 2'h0
`define OMS_TGT_PANEL 2'h1
`define OMS_TGT_NET 2'h2
`define OMS_TGT_NONE 2'h3
`define OMS_TGT_RESET 2'h0

// ==========================================================================
// Status register fields.
`define OMS_ST_MODE_LO 0
`define OMS_ST_MODE_HI 1
`define OMS_ST_RUNNING 2
`define OMS_ST_HOLD 3
`define OMS_ST_REJ_SET 4
`define OMS_ST_REJ_SW 5
`define OMS_ST_INTERLOCK 6

// ==========================================================================
// Bus answers and widths.
`define OMS_RESP_OKAY 2'h0
`define OMS_RESP_SLVERR 2'h2
`define OMS_FREQ_W 16

`endif

// ---- verilog/oms_pkg.sv ----
/*
 * Types of the operation mode selector: modes, pin groups, drive command and state.
 * Assumes oms_cfg.svh is on the include path.
 */
`include "oms_cfg.svh"

package oms_pkg;

	// ==========================================================================
	// Active operation mode.
	typedef enum logic [1:0] {OMS_EXT, OMS_PANEL, OMS_NET, OMS_COMB} oms_opmode_t;

	// ==========================================================================
	// Inputs that arrive from terminals and the local panel, outside the clock domain.
	typedef struct packed {
		logic forward_start_input;
		logic reverse_start_input;
		logic panel_forward_key;
		logic panel_reverse_key;
		logic panel_interlock_input;
		logic current_input_select;
		logic multi_speed_valid;
		logic jog_active;
		logic [`OMS_FREQ_W-1:0] analog2_freq;
		logic [`OMS_FREQ_W-1:0] analog4_freq;
		logic [`OMS_FREQ_W-1:0] multi_speed_freq;
		logic [`OMS_FREQ_W-1:0] jog_freq;
		logic [`OMS_FREQ_W-1:0] panel_freq;
	} oms_pins_t;

	// ==========================================================================
	// Network link commands, from logic on the same clock.
	typedef struct packed {
		logic start_fwd;
		logic start_rev;
		logic [`OMS_FREQ_W-1:0] freq;
	} oms_net_t;

	// ==========================================================================
	// Command towards the drive's frequency and start control.
	typedef struct packed {
		logic run_fwd;
		logic run_rev;
		logic [`OMS_FREQ_W-1:0] freq;
	} oms_drive_t;

	typedef struct packed {
		logic external_mode_indicator;
		logic panel_mode_indicator;
		logic net_mode_indicator;
	} oms_ind_t;

	// ==========================================================================
	// Whole state of the selector.
	typedef struct packed {
		logic [`OMS_SET_W-1:0] setting;
		oms_opmode_t mode;
		logic [`OMS_TGT_W-1:0] sw_target;
		logic hold;
		logic rej_set;
		logic rej_sw;
		logic aw_have;
		logic [`OMS_AW-1:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		oms_drive_t drive;
	} oms_state_t;

endpackage

// ---- verilog/oms_sync.sv ----
/*
 * Two-flop synchroniser bank for terminal and panel inputs.
 * Assumes each bit is a slow level; words are sampled as levels, not as coherent buses.
 */
`timescale 1ns/100ps

module oms_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	// ==========================================================================
	// State and its next value.
	typedef struct packed {
		logic [W-1:0] s2;
		logic [W-1:0] s1;
	} oms_sync_state_t;

	oms_sync_state_t sync_reg;
	oms_sync_state_t sync_next;

	always_comb begin
		sync_next.s1 = d;
		sync_next.s2 = sync_reg.s1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign q = sync_reg.s2;

endmodule

// ---- dv/oms_chk_sva.sv ----
/*
 * Port checker of the operation mode selector: bus answers, setting refusals, drive outputs.
 * Assumes it is bound to oms_top by the bench and oms_cfg.svh is on the include path.
 */
`timescale 1ns/100ps
`include "oms_cfg.svh"
module oms_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`OMS_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic drive_running,
	input wire oms_pkg::oms_drive_t drive_cmd,
	input wire oms_pkg::oms_ind_t mode_ind
);
	import oms_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================================================
	// Write steps.
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
	endsequence
	sequence set_wr;
		wr_taken ##0 (s_axi_awaddr == `OMS_OFS_SETTING) && s_axi_wstrb[0];
	endsequence
	sequence slverr_next;
		##1 s_axi_bvalid && s_axi_bresp == `OMS_RESP_SLVERR;
	endsequence
	// ==========================================================================
	// Assertions.
	a_reset_ext_home: assert property ($rose(aresetn) |-> mode_ind == 3'b100)
		else $error("indicators not external after reset");
	a_wr_answer: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
		else $error("write not answered two cycles after it was taken");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered next cycle");
	a_run_set_refused: assert property (set_wr ##1 drive_running |-> slverr_next)
		else $error("setting write accepted while running");
	a_bad_set_refused: assert property (
		set_wr ##0 (s_axi_wdata[2:0] == `OMS_SET_UNUSED || s_axi_wdata[31:3] != 29'h0) |-> ##1 slverr_next)
		else $error("illegal setting value accepted");
	a_good_set_okay: assert property (
		set_wr ##0 (s_axi_wdata[31:3] == 29'h0 && s_axi_wdata[2:0] != `OMS_SET_UNUSED) ##1 !drive_running
		|=> s_axi_bvalid && s_axi_bresp == `OMS_RESP_OKAY) else $error("legal setting write refused");
	a_start_exclusive: assert property (!(drive_cmd.run_fwd && drive_cmd.run_rev))
		else $error("both run directions active");
	a_net_ind_alone: assert property (
		mode_ind.net_mode_indicator |-> !mode_ind.external_mode_indicator && !mode_ind.panel_mode_indicator)
		else $error("network indicator shared");
endmodule

// ---- dv/oms_far_model.sv ----
/*
 * Model of the panel, terminal switches and network master beside the selector.
 * Assumes the bench hands it the wanted levels on aclk; levels move only at an edge.
 */
`timescale 1ns/100ps
module oms_far_model (
	input wire logic aclk,
	input wire oms_pkg::oms_pins_t pin_cmd,
	input wire oms_pkg::oms_net_t net_cmd,
	output oms_pkg::oms_pins_t pins_in,
	output oms_pkg::oms_net_t net_in
);
	import oms_pkg::*;
	// ==========================================================================
	// Outputs.
	// The interlock is the far side's own lever over panel entry.
	always_ff @(posedge aclk) begin
		pins_in <= pin_cmd;
		net_in <= net_cmd;
	end
endmodule

// ---- dv/oms_tb_top.sv ----
/*
 * Self-checking bench of the operation mode selector over AXI4-Lite.
 * Assumes oms_pkg, oms_top, oms_far_model and oms_chk are compiled first.
 */
`timescale 1ns/100ps
`include "oms_cfg.svh"
module oms_tb_top;
	import oms_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, drive_running = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	wire logic awready, wready, bvalid, arready, rvalid;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	oms_pins_t pin_cmd;
	oms_net_t net_cmd;
	wire oms_pins_t pins_in;
	wire oms_net_t net_in;
	wire oms_drive_t drive_cmd;
	wire oms_ind_t mode_ind;
	int n_mismatch = 0, checked = 0;
	always #20 aclk = ~aclk;
	oms_far_model u_far (.aclk(aclk), .pin_cmd(pin_cmd), .net_cmd(net_cmd), .pins_in(pins_in), .net_in(net_in));
	oms_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .pins_in(pins_in),
		.net_in(net_in), .drive_running(drive_running), .drive_cmd(drive_cmd), .mode_ind(mode_ind));
	// ==========================================================================
	// Expectations.
	function automatic logic [1:0] home(input logic [2:0] s);
		if (s == 3'h1) return 2'h1;
		if (s == 3'h3 || s == 3'h4) return 2'h3;
		return 2'h0;
	endfunction
	function automatic logic [2:0] ind(input logic [1:0] m);
		return {m == 2'h0 || m == 2'h3, m == 2'h1 || m == 2'h3, m == 2'h2};
	endfunction
	function automatic logic sw_ok(input logic [2:0] s, input logic [1:0] t, input logic il);
		case (s)
			3'h0: return t < 2'h2;
			3'h2: return t == 2'h0 || t == 2'h2;
			3'h6: return t != 2'h3;
			3'h7: return t == 2'h0 || (t == 2'h1 && il);
			default: return 1'b0;
		endcase
	endfunction
	// ==========================================================================
	// Bus and compare tasks.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(negedge aclk);
			ad = ad | awready;
			wd = wd | wready;
			@(posedge aclk);
			awvalid <= !ad;
			wvalid <= !wd;
		end
		do @(posedge aclk); while (!bvalid);
		r = bresp;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
	endtask
	task automatic dchk(input logic [1:0] run, input logic [15:0] f);
		repeat (6) @(posedge aclk);
		chk(32'(drive_cmd), {14'h0, run, f}, "drive command");
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ==========================================================================
	// Scenarios.
	initial begin
		logic [1:0] r;
		logic [31:0] d;
		logic [31:0] keep;
		logic ok;
		void'($urandom(32'h0A47715F));
		pin_cmd = '0;
		pin_cmd.analog2_freq = 16'($urandom);
		pin_cmd.analog4_freq = 16'($urandom);
		pin_cmd.multi_speed_freq = 16'($urandom);
		pin_cmd.jog_freq = 16'($urandom);
		pin_cmd.panel_freq = 16'($urandom);
		net_cmd = '{1'b0, 1'b0, 16'($urandom)};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`OMS_OFS_STATUS, d, r);
		chk(d, 32'h0, "status after reset");
		rd(8'h0C, d, r);
		chk(32'(r) + d, 32'(`OMS_RESP_SLVERR), "unmapped read");
		wr(8'h10, 32'h1, r);
		chk(32'(r), 32'(`OMS_RESP_SLVERR), "unmapped write");
		keep = 32'h0;
		// Every code once, then a random word wider than the field.
		for (int k = 0; k < 9; k++) begin
			d = (k == 8) ? ($urandom | 32'h8) : 32'(k);
			ok = (k != 5 && k != 8);
			wr(`OMS_OFS_SETTING, d, r);
			chk(32'(r), ok ? 32'h0 : 32'h2, "setting answer");
			keep = ok ? d : keep;
			rd(`OMS_OFS_SETTING, d, r);
			chk(d, keep, "setting readback");
		end
		wstrb <= 4'hE;
		wr(`OMS_OFS_SETTING, 32'h1, r);
		wstrb <= 4'hF;
		chk(32'(r), 32'h0, "write without byte lane");
		rd(`OMS_OFS_SETTING, d, r);
		chk(d, keep, "setting kept without byte lane");
		wr(`OMS_OFS_STATUS, 32'h30, r);
		drive_running <= 1'b1;
		wr(`OMS_OFS_SETTING, 32'h2, r);
		rd(`OMS_OFS_SETTING, d, r);
		chk(d, keep, "setting while running");
		rd(`OMS_OFS_STATUS, d, r);
		chk(32'(d[4:2]), 32'h5, "refusal flag");
		drive_running <= 1'b0;
		wr(`OMS_OFS_STATUS, 32'h30, r);
		for (int k = 0; k < 8; k++) begin
			for (int j = 0; j < 8; j++) begin
				if (k == 5) continue;
				pin_cmd.panel_interlock_input <= j[2];
				wr(`OMS_OFS_SETTING, 32'(k), r);
				repeat (2) @(posedge aclk);
				wr(`OMS_OFS_SWITCH, 32'(j[1:0]), r);
				ok = sw_ok(3'(k), j[1:0], j[2]);
				chk(32'(r), ok ? 32'h0 : 32'h2, "switch answer");
				rd(`OMS_OFS_STATUS, d, r);
				chk(d, {25'h0, j[2], !ok, 3'h0, ok ? j[1:0] : home(3'(k))}, "mode");
				chk(32'(mode_ind), 32'(ind(ok ? j[1:0] : home(3'(k)))), "indicators");
				wr(`OMS_OFS_STATUS, 32'h30, r);
			end
		end
		wr(`OMS_OFS_SETTING, 32'h3, r);
		pin_cmd.forward_start_input <= 1'b1;
		pin_cmd.panel_reverse_key <= 1'b1;
		dchk(2'b10, pin_cmd.panel_freq);
		pin_cmd.current_input_select <= 1'b1;
		dchk(2'b10, pin_cmd.analog4_freq);
		pin_cmd.multi_speed_valid <= 1'b1;
		dchk(2'b10, pin_cmd.multi_speed_freq);
		wr(`OMS_OFS_SETTING, 32'h4, r);
		dchk(2'b01, pin_cmd.multi_speed_freq);
		pin_cmd.multi_speed_valid <= 1'b0;
		dchk(2'b01, pin_cmd.analog4_freq);
		pin_cmd.current_input_select <= 1'b0;
		pin_cmd.jog_active <= 1'b1;
		dchk(2'b01, pin_cmd.jog_freq);
		wr(`OMS_OFS_SETTING, 32'h6, r);
		dchk(2'b10, pin_cmd.jog_freq);
		drive_running <= 1'b1;
		wr(`OMS_OFS_SWITCH, 32'h2, r);
		chk(32'(r), 32'h0, "switch while running");
		dchk(2'b10, pin_cmd.jog_freq);
		rd(`OMS_OFS_STATUS, d, r);
		chk(32'(d[3:0]), 32'hE, "hold status");
		drive_running <= 1'b0;
		net_cmd.start_rev <= 1'b1;
		dchk(2'b01, net_cmd.freq);
		tally_and_finish();
	end
	initial begin
		#2000000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule
bind oms_top oms_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .drive_running(drive_running),
	.drive_cmd(drive_cmd), .mode_ind(mode_ind));
